/* File: rtl/crs_busy_note.sv */
// (none)

/* File: rtl/crs_gregs.sv */
// general register file: four banks of eight nibbles with pair taps
module crs_gregs
	import crs_pkg::*;
#(
	parameter int unsigned NUM = GREG_NUM
) (
	// clock
	input  wire logic       clk,
	// write port, absolute index, wide writes index and index+1
	input  wire logic       wr_en,
	input  wire logic       wr_wide,
	input  wire logic [4:0] wr_idx,
	input  wire logic [7:0] wr_data,
	// read port, absolute index
	input  wire logic [4:0] rd_idx,
	output logic      [7:0] rd_data,
	// taps on the active bank
	input  wire logic [1:0] bank,
	output logic      [3:0] acc,
	output logic      [7:0] wide_acc,
	output logic      [7:0] ptr_de,
	output logic      [7:0] ptr_hl,
	output logic      [7:0] ptr_dl
);

	logic [3:0] mem [NUM];  // register storage, no reset: contents undefined

	// absolute index of a slot in the active bank
	function automatic logic [4:0] slot(input logic [1:0] b, input logic [2:0] r);
		slot = {b, r};
	endfunction : slot

	// nibble or pair write
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_idx] <= wr_data[3:0]; // RULE1 RULE4
			if (wr_wide) begin
				mem[5'(wr_idx + 5'h01)] <= wr_data[7:4]; // RULE3
			end
		end
	end

	// combinational taps; the top registers them
	assign rd_data  = {mem[5'(rd_idx + 5'h01)], mem[rd_idx]}; // RULE4
	assign acc      = mem[slot(bank, REG_A)]; // RULE5
	assign wide_acc = {mem[slot(bank, REG_X)], mem[slot(bank, REG_A)]}; // RULE5
	assign ptr_de   = {mem[slot(bank, REG_D)], mem[slot(bank, REG_E)]}; // RULE3
	assign ptr_hl   = {mem[slot(bank, REG_H)], mem[slot(bank, REG_L)]}; // RULE3
	assign ptr_dl   = {mem[slot(bank, REG_D)], mem[slot(bank, REG_L)]}; // RULE3

endmodule : crs_gregs

/* File: rtl/crs_pkg.sv */
// shared constants and types for the cpu register, stack and status word block
// Functional notes
// RULE1 - four banks of eight nibble registers
// RULE2 - active bank is expand flag AND choice
// RULE3 - four register pairs, three pointer pairs
// RULE4 - registers reachable as plain data memory
// RULE5 - nibble, pair and carry accumulators
// RULE6 - 8-bit pointer, bank select confines stack
// RULE7 - decrement before push, increment after pop
// RULE8 - software writes bank select, upper bits zero
// RULE9 - bank select values 0,1,2 pick banks
// RULE10 - pointer zero pushes first at top address
// RULE11 - stack wraps inside its own bank
// RULE12 - pointer and bank select undefined after reset
// RULE13 - pointer loaded wide, both read back
// RULE14 - interrupt exit pops six nibbles in order
// RULE15 - call pushes bank flags, interrupt everything
// RULE16 - returns restore flags, interrupt exit everything
// RULE17 - status word on two addresses, upper rejected
// RULE18 - carry takes add/subtract carry out
// RULE19 - carry set, clear, invert, test, bit ops
// RULE20 - carry undefined after reset
// RULE21 - skip bits set by execution only
// RULE22 - interrupt raises level, exit restores it
// RULE23 - cleared expand flag forces bank zero
// RULE24 - reserved bank select value maps to bank zero
package crs_pkg;

	// general register file shape
	localparam int unsigned GREG_NUM     = 32;
	localparam logic [11:0] GREG_BASE    = 12'h000;  // 32 nibbles, bank*8+reg
	localparam logic [6:0]  GREG_SPAN    = 7'h20;
	// register slots within a bank; pair p is slots 2p (low) and 2p+1 (high)
	localparam logic [2:0]  REG_A        = 3'h0;
	localparam logic [2:0]  REG_X        = 3'h1;
	localparam logic [2:0]  REG_L        = 3'h2;
	localparam logic [2:0]  REG_H        = 3'h3;
	localparam logic [2:0]  REG_E        = 3'h4;
	localparam logic [2:0]  REG_D        = 3'h5;
	localparam logic [1:0]  PAIR_HL      = 2'h1;
	localparam logic [1:0]  PAIR_DE      = 2'h2;

	// data memory map of the block
	localparam logic [11:0] PSW_LO_ADDR  = 12'hFB0;
	localparam logic [11:0] PSW_HI_ADDR  = 12'hFB1;
	localparam logic [11:0] STP_LO_ADDR  = 12'hF80;
	localparam logic [11:0] STP_HI_ADDR  = 12'hF81;
	localparam logic [11:0] STK_BANK_ADDR = 12'hF84;

	// stack bank numbers
	localparam logic [3:0]  STK_BANK0    = 4'h0;
	localparam logic [3:0]  STK_BANK1    = 4'h1;
	localparam logic [3:0]  STK_BANK2    = 4'h2;

	// frame layout
	localparam logic [2:0]  FRAME_LAST   = 3'h5;  // six nibbles, index 0..5
	localparam logic [1:0]  IST_TOP      = 2'h2;  // highest interrupt level

	// reset values; pointer, bank select and carry carry no meaning after reset
	localparam logic [7:0]  STP_RST      = 8'h00;
	localparam logic [1:0]  STK_BANK_RST = 2'h0;
	localparam logic        CY_RST       = 1'b0;
	localparam logic [1:0]  RBS_RST      = 2'h0;

	// commands from the sequencer
	typedef enum logic [4:0] {
		OP_NOP, OP_REG_WR, OP_PAIR_WR, OP_REG_RD, OP_SEL_RB, OP_VEC_LOAD,
		OP_ADD_WITH_CARRY, OP_SUB_WITH_BORROW,
		OP_CARRY_SET, OP_CARRY_CLR, OP_CARRY_NOT, OP_CARRY_SKT,
		OP_BIT_TO_MEM, OP_BIT_FROM_MEM, OP_BIT_AND, OP_BIT_OR, OP_BIT_XOR,
		OP_SUBR_ENTRY, OP_INTR_ENTRY, OP_SUBR_EXIT, OP_INTR_EXIT
	} crs_op_t;

	// status word: upper nibble carry and skip bits, lower nibble at FB0
	typedef struct packed {
		logic       cy;
		logic [2:0] sk;
		logic [1:0] ist;
		logic       mem_bank_expand_flag;
		logic       reg_bank_expand_flag;
	} crs_psw_t;

	// data memory access from the sequencer
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic        wide;
		logic [11:0] addr;
		logic [7:0]  wdata;
	} crs_dm_req_t;

	// nibble access to stack memory
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [11:0] addr;
		logic [3:0]  wdata;
	} crs_stk_req_t;

	// decoded region of a data memory address
	typedef enum logic [2:0] {
		AREA_NONE, AREA_GREG, AREA_PSW_LO, AREA_PSW_HI,
		AREA_STP_LO, AREA_STP_HI, AREA_STK_BANK
	} crs_area_t;

	// frame engine states
	typedef enum logic [1:0] {ST_IDLE, ST_PUSH, ST_POP_REQ, ST_POP_CAP} crs_state_t;

endpackage : crs_pkg

/* File: rtl/crs_stack_addr.sv */
// stack address generator: bank decode and wrapping pointer arithmetic
module crs_stack_addr
	import crs_pkg::*;
(
	// stack state
	input  wire logic [7:0]  stp,
	input  wire logic [1:0]  bank_sel,
	// addresses
	output logic      [11:0] addr_here,
	output logic      [11:0] addr_below
);

	logic [3:0] bank;   // decoded memory bank
	logic [7:0] below;  // pointer minus one

	// bank decode; the reserved value falls back to bank zero so no stack
	// access can land in unmapped memory
	always_comb begin
		case (bank_sel)
			2'h0:    bank = STK_BANK0; // RULE9
			2'h1:    bank = STK_BANK1; // RULE9
			2'h2:    bank = STK_BANK2; // RULE9
			default: bank = STK_BANK0; // RULE24
		endcase
	end

	// 8-bit arithmetic wraps 00 to FF inside the same bank
	assign below      = stp - 8'h01; // RULE10 RULE11
	assign addr_here  = {bank, stp}; // RULE6
	assign addr_below = {bank, below}; // RULE6 RULE11

endmodule : crs_stack_addr

/* File: rtl/crs_top.sv */
// cpu register resources: general registers, status word and stack frames
module crs_top
	import crs_pkg::*;
(
	// clock and reset
	input  wire logic         clk,
	input  wire logic         nrst,
	// command from the sequencer
	input  wire crs_op_t      op,
	input  wire logic [2:0]   op_reg,
	input  wire logic [1:0]   op_pair,
	input  wire logic [7:0]   op_data,
	input  wire logic         mem_bit,
	input  wire logic [13:0]  instr_pointer,
	input  wire logic         vec_rbe,
	input  wire logic         vec_mbe,
	input  wire logic         skip_we,
	input  wire logic [2:0]   skip_in,
	// data memory access
	input  wire crs_dm_req_t  dm_req,
	output logic              dm_ack_q,
	output logic              dm_hit_q,
	output logic [7:0]        dm_rdata_q,
	// stack memory
	output crs_stk_req_t      stk_req_q,
	input  wire logic [3:0]   stk_rdata,
	// command results
	output logic [3:0]        reg_rdata_q,
	output logic              bit_out_q,
	output logic              skip_pulse_q,
	output logic              busy_q,
	output logic              done_q,
	output logic [13:0]       restored_ip_q,
	// state taps
	output crs_psw_t          psw_q,
	output logic [7:0]        stack_top_pointer_q,
	output logic [3:0]        stack_bank_selector_q,
	output logic [1:0]        reg_bank_q,
	output logic [3:0]        acc_q,
	output logic [7:0]        wide_acc_q,
	output logic [7:0]        ptr_de_q,
	output logic [7:0]        ptr_hl_q,
	output logic [7:0]        ptr_dl_q
);

	crs_state_t  state_q;           // frame engine state
	logic [2:0]  cnt_q;             // nibble index within a frame
	logic        is_intr_q;         // frame belongs to an interrupt
	logic [3:0]  frame_q [6];       // frame nibbles, in pop order
	logic [1:0]  rbs_q;             // register bank choice
	logic [1:0]  stk_bank_q;        // stack bank select, two live bits
	logic [1:0]  act_bank;          // active register bank
	logic [11:0] addr_here;         // stack address at pointer
	logic [11:0] addr_below;        // stack address below pointer
	crs_area_t   dm_area;           // region of the current access
	logic        frame_start;       // push or pop accepted this cycle
	logic        pop_last;          // last nibble of a pop captured now
	logic        g_wr_en;           // register file write controls
	logic        g_wr_wide;
	logic [4:0]  g_wr_idx;
	logic [7:0]  g_wr_data;
	logic [4:0]  g_rd_idx;
	logic [7:0]  g_rd_data;
	logic [3:0]  acc_now;           // accumulator and pointer taps from the file
	logic [7:0]  wide_now;
	logic [7:0]  de_now;
	logic [7:0]  hl_now;
	logic [7:0]  dl_now;
	logic [4:0]  sum5;              // add with carry result
	logic [4:0]  dif5;              // subtract with borrow result

	// decode a data memory address into the block's regions
	function automatic crs_area_t area_of(input logic [11:0] a);
		if (a >= GREG_BASE && a < (GREG_BASE + 12'(GREG_SPAN))) begin
			area_of = AREA_GREG;
		end else if (a == PSW_LO_ADDR) begin
			area_of = AREA_PSW_LO;
		end else if (a == PSW_HI_ADDR) begin
			area_of = AREA_PSW_HI;
		end else if (a == STP_LO_ADDR) begin
			area_of = AREA_STP_LO;
		end else if (a == STP_HI_ADDR) begin
			area_of = AREA_STP_HI;
		end else if (a == STK_BANK_ADDR) begin
			area_of = AREA_STK_BANK;
		end else begin
			area_of = AREA_NONE;
		end
	endfunction : area_of

	assign dm_area     = area_of(dm_req.addr);
	assign act_bank    = {2{psw_q.reg_bank_expand_flag}} & rbs_q; // RULE2 RULE23
	assign frame_start = (state_q == ST_IDLE) && (op == OP_SUBR_ENTRY ||
		op == OP_INTR_ENTRY || op == OP_SUBR_EXIT || op == OP_INTR_EXIT);
	assign pop_last    = (state_q == ST_POP_CAP) && (cnt_q == FRAME_LAST);
	assign sum5        = {1'b0, acc_now} + {1'b0, op_data[3:0]} + {4'h0, psw_q.cy};
	assign dif5        = {1'b0, acc_now} - {1'b0, op_data[3:0]} - {4'h0, psw_q.cy};

	// stack address arithmetic
	crs_stack_addr i_crs_stack_addr (
		.stp        (stack_top_pointer_q),
		.bank_sel   (stk_bank_q),
		.addr_here  (addr_here),
		.addr_below (addr_below)
	);

	// general register storage
	crs_gregs i_crs_gregs (
		.clk      (clk),
		.wr_en    (g_wr_en),
		.wr_wide  (g_wr_wide),
		.wr_idx   (g_wr_idx),
		.wr_data  (g_wr_data),
		.rd_idx   (g_rd_idx),
		.rd_data  (g_rd_data),
		.bank     (act_bank),
		.acc      (acc_now),
		.wide_acc (wide_now),
		.ptr_de   (de_now),
		.ptr_hl   (hl_now),
		.ptr_dl   (dl_now)
	);

	// register file write mux; a command wins over a memory write in the
	// same cycle, the sequencer is expected not to overlap the two
	always_comb begin
		g_wr_en   = 1'b0;
		g_wr_wide = 1'b0;
		g_wr_idx  = {act_bank, op_reg};
		g_wr_data = op_data;
		if (op == OP_REG_WR) begin
			g_wr_en = 1'b1; // RULE1
		end else if (op == OP_PAIR_WR) begin
			g_wr_en   = 1'b1; // RULE3
			g_wr_wide = 1'b1;
			g_wr_idx  = {act_bank, op_pair, 1'b0};
		end else if (op == OP_ADD_WITH_CARRY) begin
			g_wr_en   = 1'b1; // RULE5
			g_wr_idx  = {act_bank, REG_A};
			g_wr_data = {4'h0, sum5[3:0]};
		end else if (op == OP_SUB_WITH_BORROW) begin
			g_wr_en   = 1'b1; // RULE5
			g_wr_idx  = {act_bank, REG_A};
			g_wr_data = {4'h0, dif5[3:0]};
		end else if (dm_req.wr && dm_area == AREA_GREG) begin
			g_wr_en   = 1'b1; // RULE4
			g_wr_wide = dm_req.wide;
			g_wr_idx  = dm_req.addr[4:0];
			g_wr_data = dm_req.wdata;
		end
	end

	// read index: a register read command, otherwise the memory address
	assign g_rd_idx = (op == OP_REG_RD) ? {act_bank, op_reg} : dm_req.addr[4:0];

	// frame engine: six nibbles pushed downward or popped upward
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q       <= ST_IDLE;
			cnt_q         <= 3'h0;
			is_intr_q     <= 1'b0;
			stk_req_q     <= '0;
			done_q        <= 1'b0;
			restored_ip_q <= 14'h0000;
			for (int i = 0; i < 6; i++) begin
				frame_q[i] <= 4'h0;
			end
		end else begin
			stk_req_q <= '0;
			done_q    <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					cnt_q <= 3'h0;
					if (frame_start) begin
						is_intr_q <= (op == OP_INTR_ENTRY || op == OP_INTR_EXIT);
					end
					if (frame_start && (op == OP_SUBR_ENTRY || op == OP_INTR_ENTRY)) begin
						state_q    <= ST_PUSH;
						frame_q[0] <= instr_pointer[11:8]; // RULE14
						frame_q[1] <= {2'b00, instr_pointer[13:12]}; // RULE14
						frame_q[2] <= instr_pointer[3:0]; // RULE14
						frame_q[3] <= instr_pointer[7:4]; // RULE14
						if (op == OP_INTR_ENTRY) begin
							frame_q[4] <= {psw_q.ist, psw_q.mem_bank_expand_flag, psw_q.reg_bank_expand_flag}; // RULE15 RULE22
							frame_q[5] <= {psw_q.cy, psw_q.sk}; // RULE15
						end else begin
							frame_q[4] <= {2'b00, psw_q.mem_bank_expand_flag, psw_q.reg_bank_expand_flag}; // RULE15
							frame_q[5] <= 4'h0;
						end
					end else if (frame_start) begin
						state_q <= ST_POP_REQ;
					end
				end
				ST_PUSH: begin
					// highest slot first, so the pop order reads upward
					stk_req_q.wr    <= 1'b1;
					stk_req_q.addr  <= addr_below; // RULE7 RULE10
					stk_req_q.wdata <= frame_q[3'(FRAME_LAST - cnt_q)];
					cnt_q           <= cnt_q + 3'h1;
					if (cnt_q == FRAME_LAST) begin
						state_q <= ST_IDLE;
						done_q  <= 1'b1;
					end
				end
				ST_POP_REQ: begin
					stk_req_q.rd   <= 1'b1;
					stk_req_q.addr <= addr_here; // RULE7
					state_q        <= ST_POP_CAP;
				end
				ST_POP_CAP: begin
					// read data is taken while the read request stands
					frame_q[cnt_q] <= stk_rdata; // RULE14
					cnt_q          <= cnt_q + 3'h1;
					if (cnt_q == FRAME_LAST) begin
						state_q       <= ST_IDLE;
						done_q        <= 1'b1;
						restored_ip_q <= {frame_q[1][1:0], frame_q[0], frame_q[3], frame_q[2]};
					end else begin
						state_q <= ST_POP_REQ;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// busy flag mirrors the engine
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			busy_q <= 1'b0;
		end else begin
			// drops on the edge that ends the frame, together with done
			busy_q <= (state_q != ST_IDLE)
				? !((state_q == ST_PUSH || state_q == ST_POP_CAP) && cnt_q == FRAME_LAST)
				: frame_start;
		end
	end

	// stack pointer: frame moves first, then a software load
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stack_top_pointer_q <= STP_RST; // RULE12
		end else if (state_q == ST_PUSH) begin
			stack_top_pointer_q <= stack_top_pointer_q - 8'h01; // RULE7 RULE11
		end else if (state_q == ST_POP_CAP) begin
			stack_top_pointer_q <= stack_top_pointer_q + 8'h01; // RULE7 RULE11
		end else if (dm_req.wr && dm_req.wide && dm_area == AREA_STP_LO) begin
			stack_top_pointer_q <= dm_req.wdata; // RULE13
		end
	end

	// stack bank select; only the two live bits are kept
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stk_bank_q <= STK_BANK_RST; // RULE12
		end else if (dm_req.wr && dm_area == AREA_STK_BANK) begin
			stk_bank_q <= dm_req.wdata[1:0]; // RULE6 RULE8
		end
	end

	// register bank choice
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rbs_q <= RBS_RST;
		end else if (op == OP_SEL_RB) begin
			rbs_q <= op_data[1:0]; // RULE23
		end
	end

	// status word: frame restore, interrupt entry, then single commands
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			psw_q    <= '0;
			psw_q.cy <= CY_RST; // RULE20
		end else if (pop_last) begin
			psw_q.mem_bank_expand_flag <= frame_q[4][1]; // RULE16
			psw_q.reg_bank_expand_flag <= frame_q[4][0]; // RULE16
			if (is_intr_q) begin
				psw_q.ist <= frame_q[4][3:2]; // RULE16 RULE22
				psw_q.cy  <= stk_rdata[3]; // RULE16
				psw_q.sk  <= stk_rdata[2:0]; // RULE16
			end
		end else if (frame_start && op == OP_INTR_ENTRY) begin
			// level steps up once, never past the top level
			psw_q.ist <= (psw_q.ist < IST_TOP) ? 2'(psw_q.ist + 2'h1) : IST_TOP; // RULE22
			psw_q.mem_bank_expand_flag <= vec_mbe;
			psw_q.reg_bank_expand_flag <= vec_rbe;
		end else begin
			case (op)
				OP_VEC_LOAD: begin
					psw_q.mem_bank_expand_flag <= vec_mbe;
					psw_q.reg_bank_expand_flag <= vec_rbe;
				end
				OP_ADD_WITH_CARRY:  psw_q.cy <= sum5[4]; // RULE18
				OP_SUB_WITH_BORROW: psw_q.cy <= dif5[4]; // RULE18
				OP_CARRY_SET:       psw_q.cy <= 1'b1; // RULE19
				OP_CARRY_CLR:       psw_q.cy <= 1'b0; // RULE19
				OP_CARRY_NOT:       psw_q.cy <= !psw_q.cy; // RULE19
				OP_BIT_FROM_MEM:    psw_q.cy <= mem_bit; // RULE19
				OP_BIT_AND:         psw_q.cy <= psw_q.cy & mem_bit; // RULE19
				OP_BIT_OR:          psw_q.cy <= psw_q.cy | mem_bit; // RULE19
				OP_BIT_XOR:         psw_q.cy <= psw_q.cy ^ mem_bit; // RULE19
				default: begin
					// memory writes reach only the lower nibble
					if (dm_req.wr && dm_area == AREA_PSW_LO) begin
						{psw_q.ist, psw_q.mem_bank_expand_flag, psw_q.reg_bank_expand_flag} <= dm_req.wdata[3:0]; // RULE17
					end
				end
			endcase
			// skip bits are moved by execution alone, never by a memory write
			if (skip_we) begin
				psw_q.sk <= skip_in; // RULE21
			end
		end
	end

	// carry results to the sequencer
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bit_out_q    <= 1'b0;
			skip_pulse_q <= 1'b0;
		end else begin
			skip_pulse_q <= (op == OP_CARRY_SKT) && psw_q.cy; // RULE19
			if (op == OP_BIT_TO_MEM) begin
				bit_out_q <= psw_q.cy; // RULE19
			end
		end
	end

	// data memory answer, one cycle after the request
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dm_ack_q   <= 1'b0;
			dm_hit_q   <= 1'b0;
			dm_rdata_q <= 8'h00;
		end else begin
			dm_ack_q <= dm_req.rd | dm_req.wr;
			dm_hit_q <= (dm_req.rd | dm_req.wr) && dm_area != AREA_NONE
				&& dm_area != AREA_PSW_HI; // RULE17
			if (dm_req.rd) begin
				if (dm_area == AREA_GREG) begin
					dm_rdata_q <= dm_req.wide ? g_rd_data : {4'h0, g_rd_data[3:0]}; // RULE4
				end else if (dm_area == AREA_PSW_LO) begin
					dm_rdata_q <= {4'h0, psw_q.ist, psw_q.mem_bank_expand_flag, psw_q.reg_bank_expand_flag}; // RULE17
				end else if (dm_area == AREA_STP_LO) begin
					dm_rdata_q <= dm_req.wide ? stack_top_pointer_q
						: {4'h0, stack_top_pointer_q[3:0]}; // RULE13
				end else if (dm_area == AREA_STP_HI) begin
					dm_rdata_q <= {4'h0, stack_top_pointer_q[7:4]}; // RULE13
				end else if (dm_area == AREA_STK_BANK) begin
					dm_rdata_q <= {6'h00, stk_bank_q}; // RULE13
				end else begin
					dm_rdata_q <= 8'h00;
				end
			end
		end
	end

	// registered taps of the register file and bank state
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata_q           <= 4'h0;
			acc_q                 <= 4'h0;
			wide_acc_q            <= 8'h00;
			ptr_de_q              <= 8'h00;
			ptr_hl_q              <= 8'h00;
			ptr_dl_q              <= 8'h00;
			reg_bank_q            <= 2'h0;
			stack_bank_selector_q <= 4'h0;
		end else begin
			if (op == OP_REG_RD) begin
				reg_rdata_q <= g_rd_data[3:0]; // RULE1
			end
			acc_q                 <= acc_now; // RULE5
			wide_acc_q            <= wide_now; // RULE5
			ptr_de_q              <= de_now; // RULE3
			ptr_hl_q              <= hl_now; // RULE3
			ptr_dl_q              <= dl_now; // RULE3
			reg_bank_q            <= act_bank; // RULE2
			stack_bank_selector_q <= {2'b00, stk_bank_q};
		end
	end

endmodule : crs_top

/* File: tb/crs_stack_mem.sv */
// stack memory model: nibble ram answering within the request cycle
module crs_stack_mem
	import crs_pkg::*;
(
	input wire logic         clk,
	input wire crs_stk_req_t stk_req,
	output logic [3:0]       stk_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] mem [0:4095];  // whole data memory span
	logic [3:0] last_q;        // last nibble shown on the read lines
	// writes land on the edge; reads remember what was shown
	always_ff @(posedge clk) begin
		if (stk_req.wr) begin
			mem[stk_req.addr] <= stk_req.wdata;
		end
		if (stk_req.rd) begin
			last_q <= mem[stk_req.addr];
		end
	end
	// idle lines show the inverse so stale data can never pass
	assign stk_rdata = stk_req.rd ? mem[stk_req.addr] : ~last_q;
endmodule : crs_stack_mem

/* File: tb/crs_top_checker.sv */
// checker: port timing and value relations of the register block
module crs_top_checker
	import crs_pkg::*;
(
	// clock, reset, stimulus
	input wire logic               clk,
	input wire logic               nrst,
	input wire crs_op_t            op,
	input wire crs_dm_req_t        dm_req,
	// observed outputs
	input wire logic               dm_ack_q,
	input wire logic               dm_hit_q,
	input wire crs_stk_req_t       stk_req_q,
	input wire logic               skip_pulse_q,
	input wire logic               busy_q,
	input wire logic               done_q,
	input wire crs_psw_t           psw_q,
	input wire logic [7:0]         stack_top_pointer_q,
	input wire logic [1:0]         reg_bank_q
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	a_ack_one_cycle: assert property ((dm_req.rd || dm_req.wr) |=> dm_ack_q)
		else $error("missing ack");
	a_psw_hi_reject: assert property (dm_req.rd && dm_req.addr == PSW_HI_ADDR |=> !dm_hit_q)
		else $error("upper status address answered");
	a_bank_forced: assert property (!psw_q.reg_bank_expand_flag [*2] |-> reg_bank_q == 2'h0)
		else $error("bank not zero");
	a_stack_bank: assert property (
		(stk_req_q.wr || stk_req_q.rd) |-> stk_req_q.addr[11:8] < 4'h3)
		else $error("stack left low banks");
	a_push_predec: assert property (
		stk_req_q.wr |-> stk_req_q.addr[7:0] == stack_top_pointer_q)
		else $error("push address");
	a_pop_postinc: assert property (stk_req_q.rd |-> stk_req_q.addr[7:0] == stack_top_pointer_q)
		else $error("pop address");
	a_push_frame: assert property (
		op == OP_SUBR_ENTRY && !busy_q |=> busy_q [*6] ##1 (done_q && !busy_q))
		else $error("call frame length");
	a_carry_set: assert property (op == OP_CARRY_SET |=> psw_q.cy)
		else $error("carry not set");
	a_skip_test: assert property (op == OP_CARRY_SKT |=> skip_pulse_q == $past(psw_q.cy))
		else $error("skip pulse wrong");
	a_level_up: assert property (op == OP_INTR_ENTRY && !busy_q && psw_q.ist < IST_TOP
		|=> psw_q.ist == $past(psw_q.ist) + 2'h1)
		else $error("level not raised");
	// main scenarios reached
	c_push: cover property (stk_req_q.wr);
	c_pop: cover property (stk_req_q.rd);
	c_skip: cover property (skip_pulse_q);
endmodule : crs_top_checker

/* File: tb/test_crs_top.sv */
// testbench for the register, stack and status word block
module test_crs_top;
	timeunit 1ns;
	timeprecision 1ps;
	import crs_pkg::*;
	logic clk, nrst, mem_bit, vec_rbe, vec_mbe, dm_ack_q, dm_hit_q, bit_out_q, skip_pulse_q;
	logic busy_q, done_q, skip_we;
	logic [2:0] skip_in;
	crs_op_t op;
	crs_dm_req_t dm_req;
	crs_stk_req_t stk_req_q;
	crs_psw_t psw_q;
	logic [7:0] op_data, dm_rdata_q, stack_top_pointer_q, wide_acc_q, ptr_de_q, ptr_hl_q, ptr_dl_q;
	logic [13:0] instr_pointer, restored_ip_q;
	logic [3:0] stk_rdata, reg_rdata_q, stack_bank_selector_q, acc_q;
	logic [1:0] reg_bank_q;
	int failures, checked, cyc;
	crs_top i_crs_top (.clk, .nrst, .op, .op_reg(3'h0), .op_pair(2'h0), .op_data, .mem_bit,
		.instr_pointer, .vec_rbe, .vec_mbe, .skip_we, .skip_in, .dm_req, .dm_ack_q,
		.dm_hit_q, .dm_rdata_q, .stk_req_q, .stk_rdata, .reg_rdata_q, .bit_out_q, .skip_pulse_q,
		.busy_q, .done_q, .restored_ip_q, .psw_q, .stack_top_pointer_q, .stack_bank_selector_q,
		.reg_bank_q, .acc_q, .wide_acc_q, .ptr_de_q, .ptr_hl_q, .ptr_dl_q);
	crs_stack_mem i_crs_stack_mem (.clk, .stk_req(stk_req_q), .stk_rdata);
	always #2.5 clk = ~clk;
	// hang guard at 5000 cycles, well beyond the fewer than two hundred cycles needed
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			end_sim();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// one data memory access; ack checked in the following cycle
	task automatic dm(input logic w, input logic wd, input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		dm_req <= '{rd: !w, wr: w, wide: wd, addr: a, wdata: d};
		@(posedge clk);
		dm_req <= '0;
		#1;
		chk(dm_ack_q, 1'b1);
	endtask : dm
	// one command; a frame command waits for its done pulse
	task automatic cmd(input crs_op_t o, input logic [7:0] d);
		@(posedge clk);
		op <= o;
		op_data <= d;
		@(posedge clk);
		op <= OP_NOP;
		#1;
		for (int i = 0; i < 20 && o >= OP_SUBR_ENTRY && done_q !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
	endtask : cmd
	task automatic t_regs();
		vec_rbe <= 1'b1;
		cmd(OP_VEC_LOAD, 8'h00);
		cmd(OP_SEL_RB, 8'h02);
		@(posedge clk);
		#1;
		chk(reg_bank_q, 2'h2);
		dm(1, 1, 12'h010, 8'hA5);
		@(posedge clk);
		#1;
		chk(wide_acc_q, 8'hA5);
		vec_rbe <= 1'b0;
		cmd(OP_VEC_LOAD, 8'h00);
		@(posedge clk);
		#1;
		chk(reg_bank_q, 2'h0);
		dm(0, 1, 12'h010, 8'h00);
		chk(dm_rdata_q, 8'hA5);
		dm(1, 1, 12'h002, 8'h3C);
		dm(1, 1, 12'h004, 8'h96);
		@(posedge clk);
		#1;
		chk(ptr_hl_q, 8'h3C);
		chk(ptr_de_q, 8'h96);
		chk(ptr_dl_q, 8'h9C);
	endtask : t_regs
	task automatic t_carry();
		crs_op_t ol[8] = '{OP_CARRY_SET, OP_CARRY_NOT, OP_CARRY_NOT, OP_CARRY_CLR,
			OP_BIT_FROM_MEM, OP_BIT_AND, OP_BIT_OR, OP_BIT_XOR};
		logic [7:0] mb = 8'b11010100;
		logic [7:0] ex = 8'b01010101;
		for (int i = 0; i < 8; i++) begin
			mem_bit <= mb[i];
			cmd(ol[i], 8'h00);
			chk(psw_q.cy, ex[i]);
			if (i == 2 || i == 3) begin
				cmd(OP_CARRY_SKT, 8'h00);
				chk(skip_pulse_q, ex[i]);
				cmd(OP_BIT_TO_MEM, 8'h00);
				chk(bit_out_q, ex[i]);
			end
		end
		cmd(OP_CARRY_CLR, 8'h00);
		dm(1, 0, 12'h000, 8'h0F);
		cmd(OP_ADD_WITH_CARRY, 8'h01);
		chk(psw_q.cy, 1'b1);
		dm(0, 0, 12'h000, 8'h00);
		chk(dm_rdata_q[3:0], 4'h0);
		cmd(OP_SUB_WITH_BORROW, 8'h01);
		chk(psw_q.cy, 1'b1);
		cmd(OP_ADD_WITH_CARRY, 8'h00);
		chk(psw_q.cy, 1'b0);
		cmd(OP_REG_WR, 8'h07);
		cmd(OP_REG_RD, 8'h00);
		chk(reg_rdata_q, 4'h7);
		chk(acc_q, 4'h7);
		cmd(OP_PAIR_WR, 8'hB4);
		@(posedge clk);
		#1;
		chk(wide_acc_q, 8'hB4);
	endtask : t_carry
	task automatic t_psw();
		dm(1, 0, PSW_LO_ADDR, 8'h03);
		dm(0, 0, PSW_LO_ADDR, 8'h00);
		chk(dm_rdata_q[3:0], 4'h3);
		dm(0, 0, PSW_HI_ADDR, 8'h00);
		chk(dm_hit_q, 1'b0);
		skip_we <= 1'b1;
		skip_in <= 3'h5;
		@(posedge clk);
		skip_we <= 1'b0;
		#1;
		chk(psw_q.sk, 3'h5);
	endtask : t_psw
	task automatic t_stack();
		dm(1, 1, STP_LO_ADDR, 8'h00);
		dm(1, 0, STK_BANK_ADDR, 8'h01);
		dm(0, 0, STK_BANK_ADDR, 8'h00);
		chk(dm_rdata_q[3:0], 4'h1);
		chk(stack_bank_selector_q, 4'h1);
		cmd(OP_CARRY_SET, 8'h00);
		instr_pointer <= 14'h2A5C;
		cmd(OP_INTR_ENTRY, 8'h00);
		chk(psw_q.ist, 2'h1);
		chk(stack_top_pointer_q, 8'hFA);
		@(posedge clk);
		#1;
		chk({i_crs_stack_mem.mem[12'h1FF], i_crs_stack_mem.mem[12'h1FE]}, 8'hD3);
		chk({i_crs_stack_mem.mem[12'h1FA], i_crs_stack_mem.mem[12'h1FB]}, 8'hA2);
		cmd(OP_CARRY_CLR, 8'h00);
		cmd(OP_INTR_EXIT, 8'h00);
		chk(psw_q, 8'hD3);
		chk(restored_ip_q, 14'h2A5C);
		chk(stack_top_pointer_q, 8'h00);
		cmd(OP_CARRY_CLR, 8'h00);
		cmd(OP_SUBR_ENTRY, 8'h00);
		chk(i_crs_stack_mem.mem[12'h1FF], 4'h0);
		cmd(OP_CARRY_SET, 8'h00);
		cmd(OP_SUBR_EXIT, 8'h00);
		chk(psw_q.cy, 1'b1);
		dm(1, 0, STK_BANK_ADDR, 8'h03);
		cmd(OP_SUBR_ENTRY, 8'h00);
		chk(i_crs_stack_mem.mem[12'h0FF], 4'h0);
	endtask : t_stack
	task automatic end_sim();
		$display("checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_sim
	initial begin
		{clk, nrst, mem_bit, vec_rbe, vec_mbe, op_data, instr_pointer, skip_we, skip_in} = '0;
		op = OP_NOP;
		dm_req = '0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		t_regs();
		t_carry();
		t_psw();
		t_stack();
		end_sim();
	end
endmodule : test_crs_top
bind crs_top crs_top_checker i_crs_top_checker (.clk, .nrst, .op, .dm_req, .dm_ack_q, .dm_hit_q,
	.stk_req_q, .skip_pulse_q, .busy_q, .done_q, .psw_q, .stack_top_pointer_q, .reg_bank_q);
